/* pin_mode_map.svh */
// Register offsets, field positions and reset values of the pin mode block
`ifndef PIN_MODE_MAP_SVH
`define PIN_MODE_MAP_SVH

// ----------------------------------------
// Register indices and byte addresses
// ----------------------------------------
`define PM_MODE_IDX        8'h04
`define PM_GIN_EN_IDX      8'h06
`define PM_MODE_ADDR       8'h10
`define PM_GIN_EN_ADDR     8'h18
`define PM_POST0_ADDR      8'h20
`define PM_POST1_ADDR      8'h24
`define PM_STATUS_ADDR     8'h28
`define PM_CFG_BASE_ADDR   8'h80
`define PM_CFG_WORDS       24

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PM_MODE_BIT_POS    0
`define PM_PRIM_CLK_POS    1
`define PM_DIV_PRE_LSB     0
`define PM_DIV_FB_LSB      8
`define PM_DIV_POST_DIVIDER_SET_SELECT_POS    20
`define PM_POST_Q_LSB      0
`define PM_POST_PM_LSB     10

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PM_MODE_RST        2'h0
`define PM_GIN_EN_RST      5'h1F
`define PM_CFG_RST         32'h0
`define PM_POST_RST        12'h000

`endif

/* pin_mode_pkg.sv */
// Types shared by the pin mode block
`default_nettype none
package pin_mode_pkg;
	typedef enum logic [1:0] {
		MODE_PLL0_PINS,
		MODE_ALL_PINS,
		MODE_I2C,
		MODE_JTAG
	} op_mode_t;

	typedef enum logic [1:0] {
		LVL_FLOAT,
		LVL_HIGH,
		LVL_LOW
	} tri_level_t;
endpackage
`default_nettype wire

/* level_sync.sv */
// Two-flop synchroniser for pin levels
`default_nettype none
module level_sync #(
	parameter int WIDTH  = 1,
	parameter int STAGES = 2
) (
	input  wire logic             clk_sys,
	input  wire logic             srst,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	// ----------------------------------------
	// Synchroniser chain
	// ----------------------------------------
	logic [WIDTH-1:0] chain_q [STAGES];

	if (STAGES < 2) begin : g_chk
		$error("level_sync needs at least two stages");
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			for (int i = 0; i < STAGES; i++) begin
				chain_q[i] <= '0;
			end
		end else begin
			chain_q[0] <= async_in;
			for (int i = 1; i < STAGES; i++) begin
				chain_q[i] <= chain_q[i-1];
			end
		end
	end

	assign sync_out = chain_q[STAGES-1];
endmodule
`default_nettype wire

/* pin_mode_select.sv */
// Multi-purpose pin mode decode and PLL configuration selection
//
// Behaviour
// - Four modes come from the mode bit and the three-level interface select pin.
// - Mode bit 1 with select pin floating gives PLL0-only pin selection.
// - Mode bit 0 with select pin floating gives all-PLL pin selection.
// - In JTAG mode general input 3 is the active-low scan logic reset.
// - Reference selector input chooses crystal/reference or the alternate clock input.
// - Output 0 is TDO in JTAG else lock loss; output 1 is clock loss.
// - Each PLL stores four divider and filter sets; two post-divider sets exist.
// - PLL0-only mode: PLL1 and PLL2 stay fixed on configuration 0.
// - PLL0-only codes 0-3 PLL0 sets, 4-5 PLL1 sets 2-3, 6-7 PLL2 sets 2-3.
// - PLL0-only mode: input 3 unused, input 4 is reference selector.
// - Each configuration's select bit picks post-divider set 1 or 0.
// - All-PLL mode: every PLL selects its set independently at run time.
// - All-PLL mode: inputs 1,0 select PLL0 configuration 0-3.
// - All-PLL mode: input 2 selects PLL1 configuration 0 or 1.
// - All-PLL mode: inputs 4,3 select PLL2 configuration 0-3.
// - Select pin high gives I2C mode; inputs 0,1 are data and clock.
// - Select pin low gives JTAG mode; inputs 0-3 are TDI, TCK, TMS, TRST.
// - A general input disabled by its enable bit reads as low for configuration and reference selection.
//
// Implementation choices: the register offsets and the Avalon-MM interface to the registers.
`include "pin_mode_map.svh"
`default_nettype none
module pin_mode_select
	import pin_mode_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        srst,
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        iface_sel_above,
	input  wire logic        iface_sel_below,
	input  wire logic        general_in_0,
	input  wire logic        general_in_1,
	input  wire logic        general_in_2,
	input  wire logic        general_in_3,
	input  wire logic        general_in_4,
	input  wire logic        jtag_tdo,
	input  wire logic        pll_lock_lost,
	input  wire logic        input_clock_lost_flag,
	output logic             general_out_0,
	output logic             general_out_1,
	output logic             serial_data_pin,
	output logic             serial_clock_pin,
	output logic             jtag_tdi,
	output logic             jtag_tck,
	output logic             jtag_tms,
	output logic             boundary_scan_trst_n,
	output logic             ref_select_alternate,
	output logic [1:0]       active_mode,
	output logic [19:0]      pll0_dividers,
	output logic [14:0]      pll0_loop_filter,
	output logic [11:0]      pll0_post_divider,
	output logic [19:0]      pll1_dividers,
	output logic [14:0]      pll1_loop_filter,
	output logic [11:0]      pll1_post_divider,
	output logic [19:0]      pll2_dividers,
	output logic [14:0]      pll2_loop_filter,
	output logic [11:0]      pll2_post_divider
);
	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [6:0] pins_s;

	level_sync #(
		.WIDTH  (7),
		.STAGES (2)
	) u_sync (
		.clk_sys  (clk_sys),
		.srst     (srst),
		.async_in ({iface_sel_below, iface_sel_above, general_in_4, general_in_3,
			general_in_2, general_in_1, general_in_0}),
		.sync_out (pins_s)
	);

	wire [4:0] gin_raw   = pins_s[4:0];
	wire       sel_above = pins_s[5];
	wire       sel_below = pins_s[6];

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [1:0]  mode_reg_q;
	logic [4:0]  gin_en_q;
	logic [11:0] post_set_q [2];
	// Word 2k is dividers of entry k, word 2k+1 its loop filter; entry = pll*4+cfg
	logic [31:0] cfg_mem_q [`PM_CFG_WORDS];
	logic        ack_q;
	logic [31:0] rdata_q;

	wire mode_bit  = mode_reg_q[`PM_MODE_BIT_POS];
	wire prim_alt  = mode_reg_q[`PM_PRIM_CLK_POS];

	// ----------------------------------------
	// Mode decode
	// ----------------------------------------
	tri_level_t lvl;
	op_mode_t   mode_d;
	op_mode_t   mode_q;

	// Contradictory comparators are treated as floating: safest, keeps pin selection
	assign lvl = (sel_above && !sel_below) ? LVL_HIGH :
		(sel_below && !sel_above) ? LVL_LOW : LVL_FLOAT;

	always_comb begin
		case (lvl)
			LVL_HIGH: mode_d = MODE_I2C;
			LVL_LOW:  mode_d = MODE_JTAG;
			default:  mode_d = mode_bit ? MODE_PLL0_PINS : MODE_ALL_PINS;
		endcase
	end

	wire pin_mode  = (mode_q == MODE_PLL0_PINS) || (mode_q == MODE_ALL_PINS);
	wire is_jtag   = (mode_q == MODE_JTAG);
	wire is_i2c    = (mode_q == MODE_I2C);

	// ----------------------------------------
	// Configuration selection
	// ----------------------------------------
	wire [4:0] gin = gin_raw & gin_en_q;

	function automatic logic [3:0] entry(input logic [1:0] pll, input logic [1:0] cfg);
		entry = {pll, cfg};
	endfunction

	logic [3:0] sel0_d;
	logic [3:0] sel1_d;
	logic [3:0] sel2_d;
	logic [3:0] sel0_q;
	logic [3:0] sel1_q;
	logic [3:0] sel2_q;

	always_comb begin
		sel0_d = sel0_q;
		sel1_d = sel1_q;
		sel2_d = sel2_q;
		case (mode_q)
			MODE_PLL0_PINS: begin
				case (gin[2:1])
					2'h2:    sel0_d = entry(2'h1, {1'b1, gin[0]});
					2'h3:    sel0_d = entry(2'h2, {1'b1, gin[0]});
					default: sel0_d = entry(2'h0, gin[1:0]);
				endcase
				sel1_d = entry(2'h1, 2'h0);
				sel2_d = entry(2'h2, 2'h0);
			end
			MODE_ALL_PINS: begin
				sel0_d = entry(2'h0, gin[1:0]);
				sel1_d = entry(2'h1, {1'b0, gin[2]});
				sel2_d = entry(2'h2, gin[4:3]);
			end
			// Programming modes hold the last selection; only a return to a pin mode changes it
			default: begin
				sel0_d = sel0_q;
			end
		endcase
	end

	function automatic logic [11:0] post_of(input logic [31:0] div_word, input logic [11:0] p0,
		input logic [11:0] p1);
		post_of = div_word[`PM_DIV_POST_DIVIDER_SET_SELECT_POS] ? p1 : p0;
	endfunction

	wire [31:0] div0_w = cfg_mem_q[{sel0_q, 1'b0}];
	wire [31:0] div1_w = cfg_mem_q[{sel1_q, 1'b0}];
	wire [31:0] div2_w = cfg_mem_q[{sel2_q, 1'b0}];

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	wire       req      = avs_read || avs_write;
	wire       wr_take  = avs_write && ack_q;
	wire       in_cfg   = avs_address >= `PM_CFG_BASE_ADDR;
	wire [7:0] cfg_off  = avs_address - `PM_CFG_BASE_ADDR;
	wire [5:0] cfg_idx  = cfg_off[7:2];
	wire       cfg_hit  = in_cfg && (cfg_idx < 6'(`PM_CFG_WORDS));
	wire [31:0] status_w = {16'h0, sel2_q[1:0], sel1_q[1:0], sel0_q, 1'b0,
		gin_raw, 2'(mode_q)};

	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0;
		case ({avs_address[7:2], 2'b00})
			`PM_MODE_ADDR:   rd_mux = {30'h0, mode_reg_q};
			`PM_GIN_EN_ADDR: rd_mux = {27'h0, gin_en_q};
			`PM_POST0_ADDR:  rd_mux = {20'h0, post_set_q[0]};
			`PM_POST1_ADDR:  rd_mux = {20'h0, post_set_q[1]};
			`PM_STATUS_ADDR: rd_mux = status_w;
			default:         rd_mux = cfg_hit ? cfg_mem_q[5'(cfg_idx)] : 32'h0;
		endcase
	end

	// One wait cycle, then the answer; unmapped reads give zero
	assign avs_waitrequest = req && !ack_q;
	assign avs_readdata    = rdata_q;

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			ack_q   <= 1'b0;
			rdata_q <= 32'h0;
		end else begin
			ack_q   <= req && !ack_q;
			rdata_q <= rd_mux;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			mode_reg_q    <= `PM_MODE_RST;
			gin_en_q      <= `PM_GIN_EN_RST;
			post_set_q[0] <= `PM_POST_RST;
			post_set_q[1] <= `PM_POST_RST;
		end else if (wr_take) begin
			case ({avs_address[7:2], 2'b00})
				`PM_MODE_ADDR:   mode_reg_q <= avs_writedata[1:0];
				`PM_GIN_EN_ADDR: gin_en_q <= avs_writedata[4:0];
				`PM_POST0_ADDR:  post_set_q[0] <= avs_writedata[11:0];
				`PM_POST1_ADDR:  post_set_q[1] <= avs_writedata[11:0];
				default:         mode_reg_q <= mode_reg_q;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			for (int i = 0; i < `PM_CFG_WORDS; i++) begin
				cfg_mem_q[i] <= `PM_CFG_RST;
			end
		end else if (wr_take && cfg_hit) begin
			cfg_mem_q[5'(cfg_idx)] <= avs_writedata;
		end
	end

	// ----------------------------------------
	// Selection and output registers
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			mode_q <= MODE_ALL_PINS;
			sel0_q <= 4'h0;
			sel1_q <= 4'h4;
			sel2_q <= 4'h8;
		end else begin
			mode_q <= mode_d;
			sel0_q <= sel0_d;
			sel1_q <= sel1_d;
			sel2_q <= sel2_d;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			pll0_dividers     <= 20'h0;
			pll1_dividers     <= 20'h0;
			pll2_dividers     <= 20'h0;
			pll0_loop_filter  <= 15'h0;
			pll1_loop_filter  <= 15'h0;
			pll2_loop_filter  <= 15'h0;
			pll0_post_divider <= 12'h0;
			pll1_post_divider <= 12'h0;
			pll2_post_divider <= 12'h0;
		end else begin
			pll0_dividers     <= div0_w[19:0];
			pll1_dividers     <= div1_w[19:0];
			pll2_dividers     <= div2_w[19:0];
			pll0_loop_filter  <= cfg_mem_q[{sel0_q, 1'b1}][14:0];
			pll1_loop_filter  <= cfg_mem_q[{sel1_q, 1'b1}][14:0];
			pll2_loop_filter  <= cfg_mem_q[{sel2_q, 1'b1}][14:0];
			pll0_post_divider <= post_of(div0_w, post_set_q[0], post_set_q[1]);
			pll1_post_divider <= post_of(div1_w, post_set_q[0], post_set_q[1]);
			pll2_post_divider <= post_of(div2_w, post_set_q[0], post_set_q[1]);
		end
	end

	// ----------------------------------------
	// Pin function outputs
	// ----------------------------------------
	// Reference select: in all-PLL mode input 4 selects a configuration, so the bit decides
	wire ref_d = pin_mode && (mode_q == MODE_ALL_PINS) ? prim_alt : gin[4];

	// Serial pins bypass the enable bits: programming must never lock itself out
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			general_out_0        <= 1'b0;
			general_out_1        <= 1'b0;
			serial_data_pin      <= 1'b1;
			serial_clock_pin     <= 1'b1;
			jtag_tdi             <= 1'b0;
			jtag_tck             <= 1'b0;
			jtag_tms             <= 1'b1;
			boundary_scan_trst_n <= 1'b0;
			ref_select_alternate <= 1'b0;
			active_mode          <= 2'h1;
		end else begin
			general_out_0        <= is_jtag ? jtag_tdo : pll_lock_lost;
			general_out_1        <= input_clock_lost_flag;
			serial_data_pin      <= is_i2c ? gin_raw[0] : 1'b1;
			serial_clock_pin     <= is_i2c ? gin_raw[1] : 1'b1;
			jtag_tdi             <= is_jtag & gin_raw[0];
			jtag_tck             <= is_jtag & gin_raw[1];
			jtag_tms             <= !is_jtag | gin_raw[2];
			boundary_scan_trst_n <= is_jtag & gin_raw[3];
			ref_select_alternate <= ref_d;
			active_mode          <= 2'(mode_q);
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	sequence float_pin_s;
		!sel_above && !sel_below;
	endsequence

	sequence jtag_pin_s;
		sel_below && !sel_above;
	endsequence

	mode_float_a: assert property (@(posedge clk_sys) disable iff (srst)
		float_pin_s ##1 1 |-> mode_q == ($past(mode_bit) ? MODE_PLL0_PINS : MODE_ALL_PINS))
		else $error("floating select pin gave wrong mode");

	mode_i2c_a: assert property (@(posedge clk_sys) disable iff (srst)
		sel_above && !sel_below |=> mode_q == MODE_I2C)
		else $error("high select pin did not give i2c mode");

	mode_jtag_a: assert property (@(posedge clk_sys) disable iff (srst)
		jtag_pin_s |=> mode_q == MODE_JTAG ##1 active_mode == 2'h3)
		else $error("low select pin did not give jtag mode");

	fixed_plls_a: assert property (@(posedge clk_sys) disable iff (srst)
		mode_q == MODE_PLL0_PINS |=> sel1_q == 4'h4 && sel2_q == 4'h8)
		else $error("pll1 or pll2 left configuration 0");

	borrow_code_a: assert property (@(posedge clk_sys) disable iff (srst)
		mode_q == MODE_PLL0_PINS && gin[2:1] == 2'h3 |=> sel0_q == {3'h5, $past(gin[0])})
		else $error("codes 6-7 did not map to pll2 sets 2-3");

	all_pll_a: assert property (@(posedge clk_sys) disable iff (srst)
		mode_q == MODE_ALL_PINS |=> sel0_q[1:0] == $past(gin[1:0]) && sel2_q[1:0] == $past(gin[4:3]))
		else $error("all-pll selection does not follow inputs");

	pll1_sel_a: assert property (@(posedge clk_sys) disable iff (srst)
		mode_q == MODE_ALL_PINS |=> sel1_q == {3'h2, $past(gin[2])})
		else $error("pll1 selection does not follow input 2");

	gin_mask_a: assert property (@(posedge clk_sys) disable iff (srst)
		!gin_en_q[0] && mode_q == MODE_ALL_PINS |=> !sel0_q[0])
		else $error("disabled input was not seen as low");

	tdo_route_a: assert property (@(posedge clk_sys) disable iff (srst)
		is_jtag |=> general_out_0 == $past(jtag_tdo))
		else $error("output 0 did not carry tdo in jtag mode");

	trst_route_a: assert property (@(posedge clk_sys) disable iff (srst)
		!is_jtag |=> boundary_scan_trst_n == 1'b0)
		else $error("scan reset released outside jtag mode");

	post_sel_a: assert property (@(posedge clk_sys) disable iff (srst)
		div0_w[`PM_DIV_POST_DIVIDER_SET_SELECT_POS] |=> pll0_post_divider == $past(post_set_q[1]))
		else $error("post-divider set 1 not applied");

	bus_wait_a: assert property (@(posedge clk_sys) disable iff (srst)
		req && !ack_q |-> avs_waitrequest ##1 (!avs_waitrequest || !req))
		else $error("bus answer not given after one wait cycle");
endmodule
`default_nettype wire

/* strap_host_model.sv */
// Board strap and host model driving the interface select pin and general inputs
`default_nettype none
module strap_host_model
	import pin_mode_pkg::*;
(
	input  wire tri_level_t want_level,
	input  wire logic       clk_sys,
	input  wire logic [4:0] want_gin,
	output logic            iface_sel_above,
	output logic            iface_sel_below,
	output logic [4:0]      gin
);
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------
	// Pin levels
	// ----------------------------------------
	// A floating pin rests mid-rail, so neither comparator trips
	// Loss flags are never looped back into the straps
	always @(posedge clk_sys) begin
		iface_sel_above <= (want_level == LVL_HIGH);
		iface_sel_below <= (want_level == LVL_LOW);
		gin <= want_gin;
	end
endmodule
`default_nettype wire

/* multipurpose_pin_mode_select_tb.sv */
// Self-checking bench for the multi-purpose pin mode decode
`include "pin_mode_map.svh"
`default_nettype none
module multipurpose_pin_mode_select_tb
	import pin_mode_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct packed {
		logic       mb;
		tri_level_t lvl;
		logic [4:0] g;
		logic [1:0] m;
		logic [3:0] e0;
		logic [3:0] e1;
		logic [3:0] e2;
	} row_t;

	logic        clk_sys, srst, avs_read, avs_write, avs_waitrequest;
	logic [7:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic        iface_sel_above, iface_sel_below, jtag_tdo, pll_lock_lost, input_clock_lost_flag;
	logic        general_out_0, general_out_1, serial_data_pin, serial_clock_pin, ref_select_alternate;
	logic        jtag_tdi, jtag_tck, jtag_tms, boundary_scan_trst_n;
	logic [1:0]  active_mode;
	logic [4:0]  gin, want_gin;
	logic [19:0] pll0_dividers, pll1_dividers, pll2_dividers;
	logic [14:0] pll0_loop_filter, pll1_loop_filter, pll2_loop_filter;
	logic [11:0] pll0_post_divider, pll1_post_divider, pll2_post_divider;
	tri_level_t  want_level;
	int          miscompares, checks;

	// Entries are pll*4+cfg; PLL0-only codes 4-7 borrow PLL1/PLL2 sets 2-3
	row_t rows [17] = '{
		'{1'b0, LVL_FLOAT, 5'h00, 2'h1, 4'h0, 4'h4, 4'h8},
		'{1'b0, LVL_FLOAT, 5'h03, 2'h1, 4'h3, 4'h4, 4'h8},
		'{1'b0, LVL_FLOAT, 5'h05, 2'h1, 4'h1, 4'h5, 4'h8},
		'{1'b0, LVL_FLOAT, 5'h0A, 2'h1, 4'h2, 4'h4, 4'h9},
		'{1'b0, LVL_FLOAT, 5'h10, 2'h1, 4'h0, 4'h4, 4'hA},
		'{1'b0, LVL_FLOAT, 5'h1F, 2'h1, 4'h3, 4'h5, 4'hB},
		'{1'b1, LVL_FLOAT, 5'h08, 2'h0, 4'h0, 4'h4, 4'h8},
		'{1'b1, LVL_FLOAT, 5'h09, 2'h0, 4'h1, 4'h4, 4'h8},
		'{1'b1, LVL_FLOAT, 5'h0A, 2'h0, 4'h2, 4'h4, 4'h8},
		'{1'b1, LVL_FLOAT, 5'h0B, 2'h0, 4'h3, 4'h4, 4'h8},
		'{1'b1, LVL_FLOAT, 5'h0C, 2'h0, 4'h6, 4'h4, 4'h8},
		'{1'b1, LVL_FLOAT, 5'h0D, 2'h0, 4'h7, 4'h4, 4'h8},
		'{1'b1, LVL_FLOAT, 5'h0E, 2'h0, 4'hA, 4'h4, 4'h8},
		'{1'b1, LVL_FLOAT, 5'h0F, 2'h0, 4'hB, 4'h4, 4'h8},
		'{1'b1, LVL_HIGH,  5'h0F, 2'h2, 4'hB, 4'h4, 4'h8},
		'{1'b1, LVL_LOW,   5'h0F, 2'h3, 4'hB, 4'h4, 4'h8},
		'{1'b0, LVL_FLOAT, 5'h00, 2'h1, 4'h0, 4'h4, 4'h8}
	};

	pin_mode_select pin_mode_select_inst (
		.clk_sys(clk_sys), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .iface_sel_above(iface_sel_above),
		.iface_sel_below(iface_sel_below), .general_in_0(gin[0]), .general_in_1(gin[1]),
		.general_in_2(gin[2]), .general_in_3(gin[3]), .general_in_4(gin[4]), .jtag_tdo(jtag_tdo),
		.pll_lock_lost(pll_lock_lost), .input_clock_lost_flag(input_clock_lost_flag),
		.general_out_0(general_out_0), .general_out_1(general_out_1), .serial_data_pin(serial_data_pin),
		.serial_clock_pin(serial_clock_pin), .jtag_tdi(jtag_tdi), .jtag_tck(jtag_tck), .jtag_tms(jtag_tms),
		.boundary_scan_trst_n(boundary_scan_trst_n), .ref_select_alternate(ref_select_alternate),
		.active_mode(active_mode), .pll0_dividers(pll0_dividers), .pll0_loop_filter(pll0_loop_filter),
		.pll0_post_divider(pll0_post_divider), .pll1_dividers(pll1_dividers),
		.pll1_loop_filter(pll1_loop_filter), .pll1_post_divider(pll1_post_divider),
		.pll2_dividers(pll2_dividers), .pll2_loop_filter(pll2_loop_filter),
		.pll2_post_divider(pll2_post_divider)
	);

	strap_host_model strap_host_model_inst (
		.want_level(want_level), .clk_sys(clk_sys), .want_gin(want_gin),
		.iface_sel_above(iface_sel_above), .iface_sel_below(iface_sel_below), .gin(gin)
	);

	// ----------------------------------------
	// Expected words and shared tasks
	// ----------------------------------------
	function automatic logic [19:0] dv(input logic [3:0] e);
		return {8'h12, e, e, e};
	endfunction
	function automatic logic [14:0] fv(input logic [3:0] e);
		return {3'h4, e, e, e};
	endfunction
	// Odd entries carry the set-one select bit, so post set alternates
	function automatic logic [11:0] pv(input logic [3:0] e);
		return e[0] ? 12'hC2A : 12'hC15;
	endfunction

	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask

	task automatic check_pll(input logic [3:0] e0, input logic [3:0] e1, input logic [3:0] e2);
		check(64'({pll0_dividers, pll0_loop_filter, pll0_post_divider}), 64'({dv(e0), fv(e0), pv(e0)}));
		check(64'({pll1_dividers, pll1_loop_filter, pll1_post_divider}), 64'({dv(e1), fv(e1), pv(e1)}));
		check(64'({pll2_dividers, pll2_loop_filter, pll2_post_divider}), 64'({dv(e2), fv(e2), pv(e2)}));
	endtask

	// Request held until waitrequest is seen low at a rising edge
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
		r = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	// Eight edges cover the strap register plus the five-edge select pin path
	task automatic set_pins(input tri_level_t l, input logic [4:0] g);
		@(posedge clk_sys);
		want_level <= l;
		want_gin <= g;
		repeat (8) @(posedge clk_sys);
	endtask

	task automatic conclude();
		$display("checks=%0d miscompares=%0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Clock, watchdog and main sequence
	// ----------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	initial begin
		repeat (20000) @(posedge clk_sys);
		miscompares++;
		conclude();
	end

	initial begin
		srst = 1'b1;
		{avs_read, avs_write, avs_address, avs_writedata} = '0;
		want_level = LVL_FLOAT;
		want_gin = 5'h00;
		{jtag_tdo, pll_lock_lost, input_clock_lost_flag} = 3'b001;
		repeat (8) @(posedge clk_sys);
		srst <= 1'b0;
		@(posedge clk_sys);
		check(64'(active_mode), 64'h1);
		check(64'({serial_data_pin, serial_clock_pin, jtag_tms, boundary_scan_trst_n}), 64'hE);
		bus(1'b0, `PM_GIN_EN_ADDR, 32'h0, q);
		check(64'(q), 64'h1F);
		bus(1'b1, 8'h30, 32'hFFFF_FFFF, q);
		bus(1'b0, 8'h30, 32'h0, q);
		check(64'(q), 64'h0);
		for (int e = 0; e < 12; e++) begin
			bus(1'b1, `PM_CFG_BASE_ADDR + 8'(8 * e), {11'h000, e[0], dv(4'(e))}, q);
			bus(1'b1, `PM_CFG_BASE_ADDR + 8'(8 * e + 4), {17'h00000, fv(4'(e))}, q);
		end
		// Power bits stay set in both post sets so no used bank is starved
		bus(1'b1, `PM_POST0_ADDR, 32'h0000_0C15, q);
		bus(1'b1, `PM_POST1_ADDR, 32'h0000_0C2A, q);
		bus(1'b0, 8'hA8, 32'h0, q);
		check(64'(q), 64'({11'h000, 1'b1, dv(4'h5)}));
		foreach (rows[i]) begin
			bus(1'b1, `PM_MODE_ADDR, {31'h0, rows[i].mb}, q);
			set_pins(rows[i].lvl, rows[i].g);
			check(64'(active_mode), 64'(rows[i].m));
			check_pll(rows[i].e0, rows[i].e1, rows[i].e2);
		end
		// Partial enable: input 4 reads low, so PLL2 drops to configuration 1
		bus(1'b1, `PM_GIN_EN_ADDR, 32'h0F, q);
		set_pins(LVL_FLOAT, 5'h1F);
		check_pll(4'h3, 4'h5, 4'h9);
		bus(1'b1, `PM_GIN_EN_ADDR, 32'h00, q);
		repeat (8) @(posedge clk_sys);
		check_pll(4'h0, 4'h4, 4'h8);
		bus(1'b1, `PM_GIN_EN_ADDR, 32'h1F, q);
		repeat (8) @(posedge clk_sys);
		check_pll(4'h3, 4'h5, 4'hB);
		bus(1'b1, `PM_MODE_ADDR, 32'h2, q);
		repeat (8) @(posedge clk_sys);
		check(64'(ref_select_alternate), 64'h1);
		bus(1'b1, `PM_MODE_ADDR, 32'h1, q);
		repeat (8) @(posedge clk_sys);
		check(64'(ref_select_alternate), 64'h1);
		bus(1'b1, `PM_GIN_EN_ADDR, 32'h0F, q);
		repeat (8) @(posedge clk_sys);
		check(64'(ref_select_alternate), 64'h0);
		bus(1'b1, `PM_GIN_EN_ADDR, 32'h1F, q);
		{jtag_tdo, pll_lock_lost, input_clock_lost_flag} <= 3'b010;
		set_pins(LVL_HIGH, 5'h1F);
		set_pins(LVL_HIGH, 5'h02);
		check(64'({serial_data_pin, serial_clock_pin, jtag_tdi, jtag_tck, jtag_tms, boundary_scan_trst_n}),
			64'h12);
		check(64'({general_out_0, general_out_1}), 64'h2);
		check_pll(4'hB, 4'h4, 4'h8);
		{jtag_tdo, pll_lock_lost, input_clock_lost_flag} <= 3'b101;
		set_pins(LVL_HIGH, 5'h1F);
		set_pins(LVL_LOW, 5'h1F);
		set_pins(LVL_LOW, 5'h15);
		check(64'({serial_data_pin, serial_clock_pin, jtag_tdi, jtag_tck, jtag_tms, boundary_scan_trst_n}),
			64'h3A);
		check(64'({general_out_0, general_out_1}), 64'h3);
		set_pins(LVL_LOW, 5'h0A);
		check(64'({serial_data_pin, serial_clock_pin, jtag_tdi, jtag_tck, jtag_tms, boundary_scan_trst_n}),
			64'h35);
		check_pll(4'hB, 4'h4, 4'h8);
		// Status word: JTAG mode, raw inputs 0A, PLL0 entry B, PLL1 and PLL2 on configuration 0
		bus(1'b0, `PM_STATUS_ADDR, 32'h0, q);
		check(64'(q), 64'hB2B);
		conclude();
	end
endmodule
`default_nettype wire
